// >>> logic/tws_pkg.sv
// shared constants, field layouts and types of the two-wire slave receiver
package tws_pkg;

  // ==========================================================================
  // register map (avalon word index)
  // ==========================================================================
  localparam logic [1:0] ADR_OWN = 2'h0;   // own_slave_address
  localparam logic [1:0] ADR_CTRL = 2'h1;  // serial_control
  localparam logic [1:0] ADR_STAT = 2'h2;  // status_code_register
  localparam logic [1:0] ADR_DATA = 2'h3;  // shift_data_register

  // ==========================================================================
  // reset values
  // ==========================================================================
  localparam logic [7:0] OWN_RST = 8'h00;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] DATA_RST = 8'hFF;

  // ==========================================================================
  // addresses and bus status codes
  // ==========================================================================
  localparam logic [7:0] GC_ADDR = 8'h00;      // general_call_address
  localparam logic [7:0] ST_OWN_ACK = 8'h60;   // own address_with_write, acked
  localparam logic [7:0] ST_OWN_LOST = 8'h68;  // same, after lost arbitration
  localparam logic [7:0] ST_GC_ACK = 8'h70;    // general call, acked
  localparam logic [7:0] ST_GC_LOST = 8'h78;   // same, after lost arbitration
  localparam logic [7:0] ST_DAT_ACK = 8'h80;   // own data byte, acked
  localparam logic [7:0] ST_DAT_NACK = 8'h88;  // own data byte, not acked
  localparam logic [7:0] ST_GCD_ACK = 8'h90;   // general call data, acked
  localparam logic [7:0] ST_GCD_NACK = 8'h98;  // general call data, not acked
  localparam logic [7:0] ST_STOP_RS = 8'hA0;   // stop or repeated start seen
  localparam logic [7:0] ST_NONE = 8'hF8;      // nothing to report
  localparam logic [7:0] PRESC_MASK = 8'hF8;   // prescaler bits always read 0

  // ==========================================================================
  // field positions
  // ==========================================================================
  localparam int unsigned LAST_BIT = 7;        // index of the last bit of a byte
  localparam logic [3:0] BYTE_LAST = 4'h7;
  localparam logic [1:0] PH_WAIT_FALL = 2'h0;  // ack slot not yet open
  localparam logic [1:0] PH_WAIT_RISE = 2'h1;  // ack slot open, clock low
  localparam logic [1:0] PH_WAIT_END = 2'h2;   // ack slot clock high

  // serial_control layout, msb first
  typedef struct packed {
    logic operation_done_flag;
    logic acknowledge_enable;
    logic start_request;
    logic stop_request;
    logic write_collision_flag;
    logic interface_enable;
    logic rsvd;
    logic interrupt_enable_bit;
  } tws_ctrl_t;

  // sampled bus lines
  typedef struct packed {
    logic scl;
    logic sda;
  } tws_line_t;

  // receive engine states
  typedef enum logic [2:0] {
    ST_IDLE,   // not addressed, monitoring
    ST_ADDR,   // shifting in the address byte
    ST_AACK,   // acknowledge slot of the address
    ST_WAIT,   // flag set, clock stretched
    ST_DATA,   // shifting in a data byte
    ST_DACK    // acknowledge slot of a data byte
  } tws_state_t;

  // own or enabled general call address hit, gated by acknowledge_enable
  function automatic logic addr_hit(input logic [7:0] rx, input logic [7:0] own,
                                    input logic ack_en);
    logic own_hit;
    logic gc_hit;
    own_hit = (rx[7:1] == own[7:1]) && !rx[0];
    gc_hit = (rx == GC_ADDR) && own[0];
    return ack_en && (own_hit || gc_hit);
  endfunction : addr_hit

endpackage : tws_pkg

// >>> logic/tws_line_sync.sv
// two-stage synchroniser for the sampled bus lines
`timescale 1ns/1ns

module tws_line_sync (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire tws_pkg::tws_line_t line_in,
  output tws_pkg::tws_line_t line_out
);

  // ==========================================================================
  // two flip-flops; the first one feeds only the second
  // ==========================================================================
  tws_pkg::tws_line_t meta_r;  // first stage, may go metastable

  // idle bus is high on both lines
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      meta_r <= 2'h3;
      line_out <= 2'h3;
    end else begin
      meta_r <= line_in;
      line_out <= meta_r;
    end
  end

endmodule : tws_line_sync

// >>> logic/tws_slave_rx.sv
// two-wire slave receiver with avalon-mm register access
//
// Added by the designer: the register offsets and register access over Avalon-MM.
`timescale 1ns/1ns

// What this block does
// - upper seven own-address bits give slave address
// - own-address lsb enables general call answer
// - write direction enters receive, read is not served
// - address with write sets flag and status
// - lost arbitration reports 68 or 78
// - cleared ack enable gives nack after byte
// - ack enable zero ignores own address, still monitors
// - sleep still acks address, then wakes part
// - hold clock low until flag is cleared
// - data register may miss byte after wake
// - own write address acked reports 60
// - general call acked reports 70
// - acked data reports 80, byte in data register
// - not acked data reports 88
// - flag clear receives next byte, ack per enable
// - after 88 leave to not addressed state
// - prescaler bits of status read as zero
// - start request after 88 issues start when free
// - general call data reports 90 or 98
// - stop or repeated start while addressed gives A0
module tws_slave_rx (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic [1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic scl_out,
  output logic scl_oe,
  output logic sda_out,
  output logic sda_oe,
  input wire logic sleep_mode,
  input wire logic arb_lost_addr,
  output logic wake_req,
  output logic start_go,
  output logic irq
);

  // ==========================================================================
  // registers and state
  // ==========================================================================
  logic wait_r;                      // avalon waitrequest
  logic [31:0] rdata_r;              // avalon read data
  logic [7:0] own_r;                 // own_slave_address
  tws_pkg::tws_ctrl_t ctrl_r;        // serial_control
  logic [7:0] code_r;                // status code
  logic [7:0] data_r;                // shift_data_register
  tws_pkg::tws_state_t state_r;      // receive engine
  tws_pkg::tws_state_t dest_r;       // where to go once the flag is cleared
  logic [3:0] bit_cnt_r;             // bits of the current byte
  logic [7:0] shift_r;               // incoming byte
  logic [1:0] ack_ph_r;              // phase inside an ack slot
  logic gc_r;                        // addressed through general call
  logic ack_plan_r;                  // ack decision for the current byte
  logic set_flag_r;                  // one-cycle: raise the done flag
  logic stop_done_r;                 // one-cycle: stop request handled
  logic sda_oe_r;                    // pulling sda low
  logic scl_oe_r;                    // pulling scl low
  logic wake_r;                      // wake-up request
  logic start_pend_r;                // start wanted once bus is free
  logic start_go_r;                  // one-cycle start trigger to the master
  logic irq_r;                       // interrupt line
  logic low_r;                       // level driven while an enable is high
  tws_pkg::tws_line_t line_s;        // synchronised lines
  tws_pkg::tws_line_t line_p_r;      // previous sample
  tws_pkg::tws_ctrl_t wr_ctrl;       // write data seen as control fields
  logic acc;                         // access completes this edge
  logic acc_wr;                      // write completes this edge
  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;
  logic [7:0] rx_byte;               // byte including the bit now sampled
  logic addressed;                   // engine is inside a transfer to us
  logic bus_busy_r;                  // between a start and a stop on the bus

  assign avs_readdata = rdata_r;
  assign avs_waitrequest = wait_r;
  assign scl_out = low_r;
  assign sda_out = low_r;
  assign scl_oe = scl_oe_r;
  assign sda_oe = sda_oe_r;
  assign wake_req = wake_r;
  assign start_go = start_go_r;
  assign irq = irq_r;

  // ==========================================================================
  // line sampling and condition detection
  // ==========================================================================
  tws_line_sync u_sync (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .line_in({scl_in, sda_in}),
    .line_out(line_s)
  );

  // previous sample, read only by the edge detectors below
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      line_p_r <= 2'h3;
    end else begin
      line_p_r <= line_s;
    end
  end

  assign scl_rise = line_s.scl && !line_p_r.scl;
  assign scl_fall = !line_s.scl && line_p_r.scl;
  // sda moving while scl stays high marks start or stop
  assign bus_start = line_s.scl && line_p_r.scl && line_p_r.sda && !line_s.sda;
  assign bus_stop = line_s.scl && line_p_r.scl && !line_p_r.sda && line_s.sda;
  assign rx_byte = {shift_r[6:0], line_s.sda};
  assign addressed = (state_r == tws_pkg::ST_AACK) || (state_r == tws_pkg::ST_DATA) ||
                     (state_r == tws_pkg::ST_DACK);

  // high lines inside someone else's frame do not make the bus free
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      bus_busy_r <= 1'b0;
    end else if (bus_start) begin
      bus_busy_r <= 1'b1;
    end else if (bus_stop) begin
      bus_busy_r <= 1'b0;
    end
  end

  // ==========================================================================
  // avalon slave: one wait cycle, then the access completes
  // ==========================================================================
  assign acc = (avs_read || avs_write) && !wait_r;
  assign acc_wr = avs_write && !wait_r && avs_byteenable[0];
  assign wr_ctrl = tws_pkg::tws_ctrl_t'(avs_writedata[7:0]);

  // waitrequest drops for exactly the completing edge
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      wait_r <= 1'b1;
    end else if (acc) begin
      wait_r <= 1'b1;
    end else if (avs_read || avs_write) begin
      wait_r <= 1'b0;
    end
  end

  // read data is fetched while waitrequest is still high
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      rdata_r <= 32'h0000_0000;
    end else if (avs_read && wait_r) begin
      unique case (avs_address)
        tws_pkg::ADR_OWN: rdata_r <= {24'h00_0000, own_r};
        tws_pkg::ADR_CTRL: rdata_r <= {24'h00_0000, ctrl_r};
        tws_pkg::ADR_STAT: rdata_r <= {24'h00_0000, code_r & tws_pkg::PRESC_MASK};
        tws_pkg::ADR_DATA: rdata_r <= {24'h00_0000, data_r};
      endcase
    end
  end

  // own address register
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      own_r <= tws_pkg::OWN_RST;
    end else if (acc_wr && avs_address == tws_pkg::ADR_OWN) begin
      own_r <= avs_writedata[7:0];
    end
  end

  // control register; hardware set of the flag wins over a software clear
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      ctrl_r <= tws_pkg::CTRL_RST;
    end else begin
      if (acc_wr && avs_address == tws_pkg::ADR_CTRL) begin
        ctrl_r.acknowledge_enable <= wr_ctrl.acknowledge_enable;
        ctrl_r.start_request <= wr_ctrl.start_request;
        ctrl_r.stop_request <= wr_ctrl.stop_request;
        ctrl_r.interface_enable <= wr_ctrl.interface_enable;
        ctrl_r.interrupt_enable_bit <= wr_ctrl.interrupt_enable_bit;
        if (wr_ctrl.operation_done_flag) begin
          ctrl_r.operation_done_flag <= 1'b0;
        end
      end
      // data writes while the bus owns the byte are collisions
      if (acc_wr && avs_address == tws_pkg::ADR_DATA) begin
        ctrl_r.write_collision_flag <= !ctrl_r.operation_done_flag;
      end
      if (stop_done_r) begin
        ctrl_r.stop_request <= 1'b0;
      end
      if (set_flag_r) begin
        ctrl_r.operation_done_flag <= 1'b1;
      end
    end
  end

  // ==========================================================================
  // receive engine
  // ==========================================================================
  // one process for the byte engine, status code and data register; the
  // ack slot is opened on the falling clock after bit eight and closed on
  // the next falling clock, so sda never moves while scl is high
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      state_r <= tws_pkg::ST_IDLE;
      dest_r <= tws_pkg::ST_IDLE;
      bit_cnt_r <= 4'h0;
      shift_r <= 8'h00;
      ack_ph_r <= tws_pkg::PH_WAIT_FALL;
      gc_r <= 1'b0;
      ack_plan_r <= 1'b0;
      set_flag_r <= 1'b0;
      stop_done_r <= 1'b0;
      sda_oe_r <= 1'b0;
      code_r <= tws_pkg::ST_NONE;
      data_r <= tws_pkg::DATA_RST;
      wake_r <= 1'b0;
      start_pend_r <= 1'b0;
      start_go_r <= 1'b0;
    end else begin
      set_flag_r <= 1'b0;
      stop_done_r <= 1'b0;
      start_go_r <= 1'b0;
      if (!sleep_mode) begin
        wake_r <= 1'b0;
      end
      if (acc_wr && avs_address == tws_pkg::ADR_DATA) begin
        data_r <= avs_writedata[7:0];
      end
      if (!ctrl_r.interface_enable) begin
        // disabled: release the bus and forget any transfer
        state_r <= tws_pkg::ST_IDLE;
        sda_oe_r <= 1'b0;
        start_pend_r <= 1'b0;
      end else if (bus_start && state_r != tws_pkg::ST_WAIT) begin
        sda_oe_r <= 1'b0;
        bit_cnt_r <= 4'h0;
        if (addressed) begin
          // repeated start ends our transfer; address follows after the clear
          code_r <= tws_pkg::ST_STOP_RS;
          set_flag_r <= 1'b1;
          state_r <= tws_pkg::ST_WAIT;
          dest_r <= tws_pkg::ST_ADDR;
        end else begin
          state_r <= tws_pkg::ST_ADDR;
        end
      end else if (bus_stop && state_r != tws_pkg::ST_WAIT) begin
        sda_oe_r <= 1'b0;
        state_r <= tws_pkg::ST_IDLE;
        if (addressed) begin
          code_r <= tws_pkg::ST_STOP_RS;
          set_flag_r <= 1'b1;
        end
      end else begin
        unique case (state_r)
          tws_pkg::ST_IDLE: begin
            // bus free: hand the pending start to the master engine
            if (start_pend_r && !bus_busy_r && line_s.scl && line_s.sda) begin
              start_go_r <= 1'b1;
              start_pend_r <= 1'b0;
            end
          end
          tws_pkg::ST_ADDR: begin
            if (scl_rise) begin
              shift_r <= rx_byte;
              bit_cnt_r <= bit_cnt_r + 4'h1;
              if (bit_cnt_r == tws_pkg::BYTE_LAST) begin
                // read direction or no hit: stay off the bus, keep monitoring
                if (tws_pkg::addr_hit(rx_byte, own_r, ctrl_r.acknowledge_enable)) begin
                  state_r <= tws_pkg::ST_AACK;
                  ack_ph_r <= tws_pkg::PH_WAIT_FALL;
                  gc_r <= (rx_byte == tws_pkg::GC_ADDR);
                  wake_r <= sleep_mode;
                end else begin
                  state_r <= tws_pkg::ST_IDLE;
                end
              end
            end
          end
          tws_pkg::ST_AACK: begin
            unique case (ack_ph_r)
              tws_pkg::PH_WAIT_FALL: if (scl_fall) begin
                sda_oe_r <= 1'b1;
                ack_ph_r <= tws_pkg::PH_WAIT_RISE;
              end
              tws_pkg::PH_WAIT_RISE: if (scl_rise) begin
                ack_ph_r <= tws_pkg::PH_WAIT_END;
              end
              default: if (scl_fall) begin
                sda_oe_r <= 1'b0;
                set_flag_r <= 1'b1;
                state_r <= tws_pkg::ST_WAIT;
                dest_r <= tws_pkg::ST_DATA;
                if (gc_r) begin
                  code_r <= arb_lost_addr ? tws_pkg::ST_GC_LOST : tws_pkg::ST_GC_ACK;
                end else begin
                  code_r <= arb_lost_addr ? tws_pkg::ST_OWN_LOST : tws_pkg::ST_OWN_ACK;
                end
              end
            endcase
          end
          tws_pkg::ST_WAIT: begin
            // a flag set this cycle is not yet visible in ctrl_r
            if (!ctrl_r.operation_done_flag && !set_flag_r) begin
              bit_cnt_r <= 4'h0;
              ack_plan_r <= ctrl_r.acknowledge_enable;
              if (ctrl_r.stop_request) begin
                // stop request in slave mode just drops to not addressed
                state_r <= tws_pkg::ST_IDLE;
                stop_done_r <= 1'b1;
              end else begin
                state_r <= dest_r;
                if (dest_r == tws_pkg::ST_IDLE) begin
                  start_pend_r <= ctrl_r.start_request;
                end
              end
            end
          end
          tws_pkg::ST_DATA: begin
            if (scl_rise) begin
              shift_r <= rx_byte;
              bit_cnt_r <= bit_cnt_r + 4'h1;
              if (bit_cnt_r == tws_pkg::BYTE_LAST) begin
                state_r <= tws_pkg::ST_DACK;
                ack_ph_r <= tws_pkg::PH_WAIT_FALL;
              end
            end
          end
          tws_pkg::ST_DACK: begin
            unique case (ack_ph_r)
              tws_pkg::PH_WAIT_FALL: if (scl_fall) begin
                sda_oe_r <= ack_plan_r;
                ack_ph_r <= tws_pkg::PH_WAIT_RISE;
              end
              tws_pkg::PH_WAIT_RISE: if (scl_rise) begin
                ack_ph_r <= tws_pkg::PH_WAIT_END;
              end
              default: if (scl_fall) begin
                sda_oe_r <= 1'b0;
                set_flag_r <= 1'b1;
                data_r <= shift_r;
                state_r <= tws_pkg::ST_WAIT;
                // a not acknowledged byte ends the transfer
                dest_r <= ack_plan_r ? tws_pkg::ST_DATA : tws_pkg::ST_IDLE;
                if (gc_r) begin
                  code_r <= ack_plan_r ? tws_pkg::ST_GCD_ACK : tws_pkg::ST_GCD_NACK;
                end else begin
                  code_r <= ack_plan_r ? tws_pkg::ST_DAT_ACK : tws_pkg::ST_DAT_NACK;
                end
              end
            endcase
          end
        endcase
      end
    end
  end

  // ==========================================================================
  // bus drivers and interrupt
  // ==========================================================================
  // stretch the clock while software owns the byte; a long wake-up keeps
  // the whole bus blocked, which is the price of not losing the transfer
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      scl_oe_r <= 1'b0;
    end else begin
      scl_oe_r <= ctrl_r.interface_enable && state_r == tws_pkg::ST_WAIT;
    end
  end

  // both open-drain outputs only ever pull low
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      low_r <= 1'b0;
    end else begin
      low_r <= 1'b0;
    end
  end

  // level interrupt follows the flag
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= ctrl_r.operation_done_flag && ctrl_r.interrupt_enable_bit;
    end
  end

  // ==========================================================================
  // checks
  // ==========================================================================
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  irq_follows_a: assert property (ctrl_r.operation_done_flag && ctrl_r.interrupt_enable_bit
    |=> irq_r) else $error("interrupt not raised for set flag");

  scl_hold_a: assert property (state_r == tws_pkg::ST_WAIT && ctrl_r.interface_enable
    && ctrl_r.operation_done_flag |=> scl_oe_r) else $error("clock not held in wait");

  flag_sets_a: assert property (set_flag_r |=> ctrl_r.operation_done_flag)
    else $error("flag not set after event");

  presc_zero_a: assert property (avs_read && wait_r && avs_address == tws_pkg::ADR_STAT
    |=> rdata_r[2:0] == 3'h0) else $error("prescaler bits not zero");

  no_ack_off_a: assert property (state_r == tws_pkg::ST_ADDR && scl_rise
    && bit_cnt_r == tws_pkg::BYTE_LAST && !ctrl_r.acknowledge_enable
    && ctrl_r.interface_enable && !bus_start && !bus_stop
    |=> state_r == tws_pkg::ST_IDLE) else $error("address taken with ack off");

  gc_ignored_a: assert property (state_r == tws_pkg::ST_ADDR && scl_rise
    && bit_cnt_r == tws_pkg::BYTE_LAST && rx_byte == tws_pkg::GC_ADDR && !own_r[0]
    |=> state_r != tws_pkg::ST_AACK) else $error("general call taken while off");

  nack_quiet_a: assert property (state_r == tws_pkg::ST_DACK && !ack_plan_r
    |-> !sda_oe_r) else $error("sda pulled for a nack");

  own_code_a: assert property (set_flag_r && !gc_r && $past(state_r) == tws_pkg::ST_AACK
    && !$past(arb_lost_addr) |-> code_r == tws_pkg::ST_OWN_ACK)
    else $error("wrong code for own address");

  data_code_a: assert property (set_flag_r && $past(state_r) == tws_pkg::ST_DACK
    && !gc_r && ack_plan_r |-> code_r == tws_pkg::ST_DAT_ACK && data_r == shift_r)
    else $error("wrong code or byte for acked data");

  resume_a: assert property (state_r == tws_pkg::ST_WAIT && !ctrl_r.operation_done_flag
    && !set_flag_r && !ctrl_r.stop_request && dest_r == tws_pkg::ST_DATA
    && ctrl_r.interface_enable ##1 state_r == tws_pkg::ST_DATA
    |-> ack_plan_r == $past(ctrl_r.acknowledge_enable)) else $error("resume wrong");

endmodule : tws_slave_rx

// >>> sim/tws_master_model.sv
// bus master model that drives the slave receiver's two wires
`timescale 1ns/1ns

module tws_master_model (
  input wire logic scl_oe,
  input wire logic sda_oe,
  output logic scl_line,
  output logic sda_line
);
  // ==========================================================================
  // open-drain wires with pull-ups
  // ==========================================================================
  localparam int Q = 31; // quarter of the 125 ns link period
  logic m_scl = 1'b1; // 1 = released by the master
  logic m_sda = 1'b1;
  assign scl_line = m_scl & ~scl_oe;
  assign sda_line = m_sda & ~sda_oe;
  // release the clock and honour stretching, bounded so a stuck slave ends
  task automatic hi();
    int n;
    n = 0;
    m_scl = 1'b1;
    while (!scl_line && n < 9999) begin
      #1 n++;
    end
    #Q;
  endtask : hi
  // data falls while the clock is high
  task automatic start();
    m_sda = 1'b0;
    #Q m_scl = 1'b0;
    #Q;
  endtask : start
  // msb first, then a released ack slot; data only moves with clock low
  task automatic send(input logic [7:0] b, output logic ack);
    for (int i = 8; i >= 0; i--) begin
      m_sda = (i == 0) ? 1'b1 : b[i-1];
      #Q hi();
      ack = sda_line;
      #Q m_scl = 1'b0;
      #(Q + 1);
    end
  endtask : send
  // data rises while the clock is high
  task automatic stop();
    m_sda = 1'b0;
    #Q hi();
    m_sda = 1'b1;
    #Q;
  endtask : stop
endmodule : tws_master_model

// >>> sim/tws_slave_rx_bench.sv
// self-checking bench of the two-wire slave receiver
`timescale 1ns/1ns

module tws_slave_rx_bench;
  // ==========================================================================
  // clock, bus and line signals
  // ==========================================================================
  logic sys_clk = 1'b0;
  logic resetn = 1'b0;
  logic [1:0] adr = 2'h0;
  logic rd_en = 1'b0;
  logic wr_en = 1'b0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic wreq, scl_in, sda_in, scl_oe, sda_oe, irq, ack, wake, go, scl_lo, sda_lo;
  logic sleep = 1'b0, lost = 1'b0, go_seen = 1'b0;
  int n_errors = 0;
  int tests_run = 0;
  initial begin
    forever #2 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    if (go) go_seen <= 1'b1;
  end
  tws_slave_rx tws_slave_rx_i (.sys_clk(sys_clk), .resetn(resetn), .avs_address(adr),
    .avs_read(rd_en), .avs_write(wr_en), .avs_writedata(wdat), .avs_byteenable(4'h1),
    .avs_readdata(rdat), .avs_waitrequest(wreq), .scl_in(scl_in), .sda_in(sda_in),
    .scl_out(scl_lo), .scl_oe(scl_oe), .sda_out(sda_lo), .sda_oe(sda_oe), .sleep_mode(sleep),
    .arb_lost_addr(lost), .wake_req(wake), .start_go(go), .irq(irq));
  tws_master_model m (.scl_oe(scl_oe), .sda_oe(sda_oe), .scl_line(scl_in), .sda_line(sda_in));
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value %s exp %h got %h", nm, exp, got);
    end
  endtask : chk
  // one access, held until waitrequest is sampled low at an edge
  task automatic bus(input logic w, input logic [1:0] a, input logic [7:0] d,
                     output logic [31:0] q);
    @(posedge sys_clk);
    adr <= a;
    wr_en <= w;
    rd_en <= ~w;
    wdat <= {24'h0, d};
    do begin
      @(posedge sys_clk);
    end while (wreq);
    q = rdat;
    wr_en <= 1'b0;
    rd_en <= 1'b0;
  endtask : bus
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : wr
  // poll the done flag, then judge the status code
  task automatic code(input logic [7:0] c);
    logic [31:0] q;
    q = 32'h0;
    for (int n = 0; n < 99 && !q[7]; n++) bus(1'b0, tws_pkg::ADR_CTRL, 8'h00, q);
    bus(1'b0, tws_pkg::ADR_STAT, 8'h00, q);
    chk("status", q, {24'h0, c});
  endtask : code
  task automatic t_reset();
    logic [31:0] q;
    bus(1'b0, tws_pkg::ADR_STAT, 8'h00, q);
    chk("idle status", q, 32'hF8);
    chk("pin level", {scl_lo, sda_lo}, 32'h0);
    $display("test reset done");
  endtask : t_reset
  task automatic t_own();
    logic [31:0] q;
    wr(tws_pkg::ADR_OWN, 8'hA5); // address 52, general call on
    wr(tws_pkg::ADR_CTRL, 8'h45);
    m.start();
    m.send(8'hA4, ack);
    chk("addr ack", ack, 1'b0);
    code(tws_pkg::ST_OWN_ACK);
    chk("irq", irq, 1'b1);
    wr(tws_pkg::ADR_CTRL, 8'hC4);
    m.send(8'h3C, ack);
    code(tws_pkg::ST_DAT_ACK);
    bus(1'b0, tws_pkg::ADR_DATA, 8'h00, q);
    chk("data", q, 32'h3C);
    wr(tws_pkg::ADR_CTRL, 8'h84); // clear with acknowledge off
    m.send(8'h5A, ack);
    chk("nack", ack, 1'b1);
    code(tws_pkg::ST_DAT_NACK);
    wr(tws_pkg::ADR_CTRL, 8'hE4); // clear, start once the bus is free
    m.send(8'h11, ack);
    chk("ignored", ack, 1'b1);
    chk("start early", go_seen, 1'b0);
    m.stop();
    repeat (4) @(posedge sys_clk);
    chk("start free", go_seen, 1'b1);
    $display("test own done");
  endtask : t_own
  task automatic t_gc();
    m.start();
    m.send(8'h00, ack);
    chk("gc ack", ack, 1'b0);
    code(tws_pkg::ST_GC_ACK);
    wr(tws_pkg::ADR_CTRL, 8'hC4);
    m.send(8'h77, ack);
    code(tws_pkg::ST_GCD_ACK);
    wr(tws_pkg::ADR_CTRL, 8'hC4);
    m.stop();
    code(tws_pkg::ST_STOP_RS);
    wr(tws_pkg::ADR_CTRL, 8'hC4);
    $display("test general call done");
  endtask : t_gc
  task automatic t_off();
    wr(tws_pkg::ADR_CTRL, 8'h04); // acknowledge off isolates the slave
    m.start();
    m.send(8'hA4, ack);
    chk("off ack", ack, 1'b1);
    m.stop();
    wr(tws_pkg::ADR_OWN, 8'hA4); // general call off
    wr(tws_pkg::ADR_CTRL, 8'h44);
    m.start();
    m.send(8'h00, ack);
    chk("gc off", ack, 1'b1);
    m.stop();
    $display("test ack off done");
  endtask : t_off
  task automatic t_lost();
    @(posedge sys_clk);
    sleep <= 1'b1;
    lost <= 1'b1;
    m.start();
    m.send(8'hA4, ack);
    chk("sleep ack", ack, 1'b0);
    chk("wake", wake, 1'b1);
    code(tws_pkg::ST_OWN_LOST);
    chk("scl held", scl_oe, 1'b1);
    sleep <= 1'b0;
    lost <= 1'b0;
    wr(tws_pkg::ADR_CTRL, 8'hC4);
    m.stop();
    code(tws_pkg::ST_STOP_RS);
    wr(tws_pkg::ADR_CTRL, 8'hC4);
    $display("test lost done");
  endtask : t_lost
  task automatic results();
    $display("checks %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : results
  // watchdog: the run needs some 3k cycles, this allows about 50k
  initial begin
    #200000;
    n_errors++;
    results();
  end
  initial begin
    repeat (6) @(posedge sys_clk);
    resetn <= 1'b1;
    t_reset();
    t_own();
    t_gc();
    t_off();
    t_lost();
    results();
  end
endmodule : tws_slave_rx_bench
